// ---- hdl/sfwdg_pkg.sv ----
// Purpose: shared constants for the software fault watchdog
// Assumes: 100 MHz clock, classic Wishbone slave, 8-bit register
// Notes:   register index 0x2e sits at byte address 4 * index
package sfwdg_pkg;
   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [7:0]  WATCHDOG_CONTROL_IDX  = 8'h2E;
   localparam logic [9:0]  WATCHDOG_CONTROL_ADDR =
      {WATCHDOG_CONTROL_IDX, 2'b00};
   localparam logic [9:0]  OPTION_STATUS_ADDR    = 10'h0BC;
   localparam logic [7:0]  CONTROL_RESET         = 8'h7F;
   localparam int          ACTIVATION_POS        = 7;
   localparam int          COUNT_TOP_POS         = 6;
   localparam logic [31:0] UNMAPPED_READ         = 32'h0000_0000;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int          CLOCK_MHZ             = 100;
   localparam int          CPU_MHZ               = 8;
   localparam int          PRESCALE_CPU_CYCLES   = 16000;
   // 16000 machine cycles of the 8 MHz part are spread over clock cycles
   localparam int          PRESCALE_CYCLES       =
      PRESCALE_CPU_CYCLES * CLOCK_MHZ / CPU_MHZ;
   localparam int          PRESCALE_W            = 18;
   localparam int          COUNT_W               = 7;
endpackage : sfwdg_pkg

// ---- hdl/sfwdg_tick_if.sv ----
// Purpose: tick carrier between prescaler and watchdog core
// Assumes: single clock domain
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface sfwdg_tick_if;
   logic tick;
   modport source (output tick);
   modport sink   (input tick);
endinterface : sfwdg_tick_if
`default_nettype wire

// ---- hdl/sfwdg_prescaler.sv ----
// Purpose: divides the clock into one tick per countdown period
// Assumes: synchronous active-low reset
// Notes:   free running, never restarted by register writes
`timescale 1ns/1ns
`default_nettype none
module sfwdg_prescaler #(
   parameter int PERIOD = sfwdg_pkg::PRESCALE_CYCLES
) (
   input  wire logic   clock,
   input  wire logic   resetn,
   sfwdg_tick_if.source tick_if
);
   logic [sfwdg_pkg::PRESCALE_W-1:0] div_q;
   logic                              tick_q;
   localparam int                     W    = sfwdg_pkg::PRESCALE_W;
   localparam logic [W-1:0]           LAST = W'(PERIOD - 1);

   always_ff @(posedge clock) begin
      if (!resetn) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q == LAST) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end
   assign tick_if.tick = tick_q;

   property p_tick_spacing;
      @(posedge clock) disable iff (!resetn)
         tick_q |=> !tick_q;
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("prescaler ticks back to back");
endmodule : sfwdg_prescaler
`default_nettype wire

// ---- hdl/sfwdg_top.sv ----
// Purpose: software fault watchdog with Wishbone register access
// Assumes: one clock at 100 MHz, synchronous active-low reset
// Notes:   reset request to the reset manager pulses one cycle per rollover or software reset write; a halt reset lasts while halt_request is high
`timescale 1ns/1ns
`default_nettype none
module sfwdg_top #(
   parameter int PRESCALE_PERIOD = sfwdg_pkg::PRESCALE_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        hw_watchdog_option,
   input  wire logic        halt_reset_option,
   input  wire logic        halt_request,
   output logic             halt_enter,
   output logic             reset_request
);
   // ***************************************************
   // state
   // ***************************************************
   logic                           active_q;
   logic [sfwdg_pkg::COUNT_W-1:0] count_q;
   logic                           enabled;
   logic                           wr_ctrl;
   logic                           rd_hit;
   logic                           rollover;
   logic                           sw_reset;
   logic                           halt_reset;
   logic [7:0]                     ctrl_view;

   sfwdg_tick_if tick_bus ();

   sfwdg_prescaler #(
      .PERIOD (PRESCALE_PERIOD)
   ) u_prescaler (
      .clock   (clock),
      .resetn  (resetn),
      .tick_if (tick_bus.source)
   );

   // ***************************************************
   // bus decode
   // ***************************************************
   logic req;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // low byte lane carries the register
   assign wr_ctrl = req && wb_we_i && wb_sel_i[0]
                    && (wb_adr_i[9:0] == sfwdg_pkg::WATCHDOG_CONTROL_ADDR);

   assign enabled   = active_q || hw_watchdog_option;
   assign ctrl_view = {active_q, count_q};

   // ***************************************************
   // control register
   // ***************************************************
   always_ff @(posedge clock) begin
      if (!resetn) begin
         active_q <=
            sfwdg_pkg::CONTROL_RESET[sfwdg_pkg::ACTIVATION_POS];
      end else if (wr_ctrl && wb_dat_i[sfwdg_pkg::ACTIVATION_POS]) begin
         active_q <= 1'b1;
      end
   end

   // write takes priority over a tick in the same cycle
   always_ff @(posedge clock) begin
      if (!resetn) begin
         count_q <= sfwdg_pkg::CONTROL_RESET[sfwdg_pkg::COUNT_W-1:0];
      end else if (wr_ctrl) begin
         count_q <= wb_dat_i[sfwdg_pkg::COUNT_W-1:0];
      end else if (tick_bus.tick) begin
         count_q <= count_q - 1'b1;
      end
   end

   // ***************************************************
   // reset generation
   // ***************************************************
   assign rollover   = !wr_ctrl && tick_bus.tick
                       && (count_q == 7'h40) && enabled;
   assign sw_reset   = wr_ctrl && !wb_dat_i[sfwdg_pkg::COUNT_TOP_POS]
                       && (wb_dat_i[sfwdg_pkg::ACTIVATION_POS]
                           || enabled);
   assign halt_reset = halt_request && enabled && halt_reset_option;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         reset_request <= 1'b0;
      end else begin
         reset_request <= rollover || sw_reset || halt_reset;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         halt_enter <= 1'b0;
      end else begin
         halt_enter <= halt_request && !halt_reset;
      end
   end

   // ***************************************************
   // bus answer
   // ***************************************************
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         wb_dat_o <= sfwdg_pkg::UNMAPPED_READ;
      end else if (req && !wb_we_i) begin
         if (wb_adr_i[9:0] == sfwdg_pkg::WATCHDOG_CONTROL_ADDR) begin
            wb_dat_o <= {24'h00_0000, ctrl_view};
         end else if (wb_adr_i[9:0] == sfwdg_pkg::OPTION_STATUS_ADDR) begin
            wb_dat_o <= {29'h0000_0000, enabled,
                         halt_reset_option, hw_watchdog_option};
         end else begin
            wb_dat_o <= sfwdg_pkg::UNMAPPED_READ;
         end
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   property p_rollover_reset;
      @(posedge clock) disable iff (!resetn)
         (tick_bus.tick && !wr_ctrl && count_q == 7'h40 && enabled)
            |=> reset_request && count_q == 7'h3F;
   endproperty
   a_rollover_reset: assert property (p_rollover_reset)
      else $error("rollover did not request reset");

   property p_no_reset_idle;
      @(posedge clock) disable iff (!resetn)
         (!enabled && !wr_ctrl && !halt_request) |=> !reset_request;
   endproperty
   a_no_reset_idle: assert property (p_no_reset_idle)
      else $error("inactive watchdog requested reset");

   property p_count_runs;
      @(posedge clock) disable iff (!resetn)
         (tick_bus.tick && !wr_ctrl) |=> count_q == $past(count_q) - 7'h01;
   endproperty
   a_count_runs: assert property (p_count_runs)
      else $error("count did not decrement on tick");

   property p_active_sticky;
      @(posedge clock) disable iff (!resetn)
         active_q |=> active_q;
   endproperty
   a_active_sticky: assert property (p_active_sticky)
      else $error("activation bit cleared without reset");

   property p_sw_reset;
      @(posedge clock) disable iff (!resetn)
         (wr_ctrl && wb_dat_i[7] && !wb_dat_i[6]) |=> reset_request;
   endproperty
   a_sw_reset: assert property (p_sw_reset)
      else $error("software reset write ignored");

   property p_halt_reset;
      @(posedge clock) disable iff (!resetn)
         (halt_request && enabled && halt_reset_option)
            |=> reset_request && !halt_enter;
   endproperty
   a_halt_reset: assert property (p_halt_reset)
      else $error("halt did not become reset");

   property p_hw_option;
      @(posedge clock) disable iff (!resetn)
         hw_watchdog_option |-> enabled;
   endproperty
   a_hw_option: assert property (p_hw_option)
      else $error("hardware option not forcing active");

   property p_reset_value;
      @(posedge clock)
         !resetn |=> ctrl_view == 8'h7F;
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("control register reset value wrong");

   property p_pulse;
      @(posedge clock) disable iff (!resetn)
         (reset_request && !wr_ctrl && !halt_request) |=> !reset_request;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("reset request longer than one cycle");

   property p_ack_once;
      @(posedge clock) disable iff (!resetn)
         wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("ack held two cycles");

   // ***************************************************
   // check helpers
   // ***************************************************
   // cycles since the last tick; checks the divider from outside
   localparam int                 GAP_W    = sfwdg_pkg::PRESCALE_W;
   localparam logic [GAP_W-1:0]   GAP_FULL = GAP_W'(PRESCALE_PERIOD);
   logic [GAP_W-1:0]              gap_q;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         gap_q <= '0;
      end else if (tick_bus.tick) begin
         gap_q <= GAP_W'(1);
      end else begin
         gap_q <= gap_q + 1'b1;
      end
   end

   property p_tick_period;
      @(posedge clock) disable iff (!resetn)
         tick_bus.tick |-> gap_q == GAP_FULL;
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("tick spacing differs from the period");

   property p_tick_due;
      @(posedge clock) disable iff (!resetn)
         !tick_bus.tick |-> gap_q < GAP_FULL;
   endproperty
   a_tick_due: assert property (p_tick_due)
      else $error("tick missing after a full period");

   property p_count_hold;
      @(posedge clock) disable iff (!resetn)
         (!tick_bus.tick && !wr_ctrl) |=> $stable(count_q);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("count moved without tick or write");

   property p_write_load;
      @(posedge clock) disable iff (!resetn)
         wr_ctrl |=> count_q == $past(wb_dat_i[6:0]);
   endproperty
   a_write_load: assert property (p_write_load)
      else $error("written count not loaded");

   property p_set_active;
      @(posedge clock) disable iff (!resetn)
         (wr_ctrl && wb_dat_i[7]) |=> active_q;
   endproperty
   a_set_active: assert property (p_set_active)
      else $error("activation write not taken");

   property p_zero_write_keeps;
      @(posedge clock) disable iff (!resetn)
         (wr_ctrl && !wb_dat_i[7]) |=> active_q == $past(active_q);
   endproperty
   a_zero_write_keeps: assert property (p_zero_write_keeps)
      else $error("writing zero changed activation");

   property p_sw_reset_enabled;
      @(posedge clock) disable iff (!resetn)
         (wr_ctrl && !wb_dat_i[6] && enabled) |=> reset_request;
   endproperty
   a_sw_reset_enabled: assert property (p_sw_reset_enabled)
      else $error("top bit cleared while active gave no reset");

   property p_safe_write;
      @(posedge clock) disable iff (!resetn)
         (wr_ctrl && wb_dat_i[6] && !halt_request) |=> !reset_request;
   endproperty
   a_safe_write: assert property (p_safe_write)
      else $error("refresh write caused a reset");

   property p_halt_pass;
      @(posedge clock) disable iff (!resetn)
         (halt_request && !(enabled && halt_reset_option)) |=> halt_enter;
   endproperty
   a_halt_pass: assert property (p_halt_pass)
      else $error("halt not passed on");

   property p_read_view;
      @(posedge clock) disable iff (!resetn)
         (req && !wb_we_i
          && wb_adr_i[9:0] == sfwdg_pkg::WATCHDOG_CONTROL_ADDR)
            |=> wb_dat_o == {24'h00_0000, $past(ctrl_view)};
   endproperty
   a_read_view: assert property (p_read_view)
      else $error("control read returned wrong value");

   property p_reset_quiet;
      @(posedge clock)
         !resetn |=> !reset_request && !halt_enter && !wb_ack_o;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not quiet after reset");

   property p_ack_after_req;
      @(posedge clock) disable iff (!resetn)
         (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
   endproperty
   a_ack_after_req: assert property (p_ack_after_req)
      else $error("request not acknowledged next cycle");

   property p_no_ack_idle;
      @(posedge clock) disable iff (!resetn)
         !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
   endproperty
   a_no_ack_idle: assert property (p_no_ack_idle)
      else $error("ack without request");
endmodule : sfwdg_top
`default_nettype wire

// ---- sim/sfwdg_testbench.sv ----
// Purpose: self-checking bench for the software fault watchdog
// Assumes: count step shortened to 8 clocks per decrement
// Notes:   each bus request is held until ack is sampled high
`timescale 1ns/1ns
`default_nettype none
module testbench;
   // ***************************************************
   // stimulus, design and monitors
   // ***************************************************
   localparam int          PER = 8;
   localparam logic [11:0] CTL = {2'b00, sfwdg_pkg::WATCHDOG_CONTROL_ADDR};
   localparam logic [11:0] OPT = {2'b00, sfwdg_pkg::OPTION_STATUS_ADDR};
   logic        clock        = 1'b0;
   logic        resetn       = 1'b0;
   logic        cyc          = 1'b0;
   logic        stb          = 1'b0;
   logic        we           = 1'b0;
   logic [3:0]  sel          = 4'h1;
   logic [11:0] adr          = 12'h000;
   logic [31:0] dati         = 32'h0000_0000;
   logic [31:0] dato;
   logic        ack;
   logic        hw           = 1'b0;
   logic        hopt         = 1'b0;
   logic        hreq         = 1'b0;
   logic        henter;
   logic        rreq;
   logic [31:0] q;
   int          num_errors   = 0;
   int          total_checks = 0;
   int          rst_seen     = 0;
   int          halt_seen    = 0;

   sfwdg_top #(.PRESCALE_PERIOD(PER)) sfwdg_top_inst (
      .clock              (clock),
      .resetn             (resetn),
      .wb_cyc_i           (cyc),
      .wb_stb_i           (stb),
      .wb_we_i            (we),
      .wb_adr_i           (adr),
      .wb_sel_i           (sel),
      .wb_dat_i           (dati),
      .wb_dat_o           (dato),
      .wb_ack_o           (ack),
      .hw_watchdog_option (hw),
      .halt_reset_option  (hopt),
      .halt_request       (hreq),
      .halt_enter         (henter),
      .reset_request      (rreq)
   );

   always #5 clock = ~clock;
   // pulses are counted, so a stretched pulse shows as extra counts
   always @(posedge clock) begin
      rst_seen += int'(rreq === 1'b1);
      halt_seen += int'(henter === 1'b1);
   end
   // ***************************************************
   // tasks
   // ***************************************************
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      dati <= {24'h00_0000, d};
      // no cycle limit here: the bench watchdog ends a hung wait
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1);
      // taken one edge after the request, ack seen at the next
      chk("ack latency", 32'h0000_0002, n);
      q = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock);
   endtask : bus

   task automatic rst_dut;
      resetn <= 1'b0;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
   endtask : rst_dut

   task automatic halt_try(input logic opt, input int er, input int eh);
      int r0;
      int h0;
      r0 = rst_seen;
      h0 = halt_seen;
      hopt <= opt;
      @(posedge clock);
      hreq <= 1'b1;
      @(posedge clock);
      hreq <= 1'b0;
      repeat (4) @(posedge clock);
      chk("halt reset", r0 + er, rst_seen);
      chk("halt enter", h0 + eh, halt_seen);
   endtask : halt_try

   task automatic roll(input logic [7:0] v, input int er);
      int r0;
      r0 = rst_seen;
      bus(1'b1, CTL, v);
      // two steps from 41h reach 3Fh well inside this span
      repeat (40) @(posedge clock);
      chk("rollover reset", r0 + er, rst_seen);
   endtask : roll

   task automatic t_reset;
      bus(1'b0, CTL, 8'h00);
      chk("control reset", 32'h0000_007F, q);
      bus(1'b0, OPT, 8'h00);
      chk("enable after reset", 32'h0000_0000, q);
      bus(1'b0, 12'h004, 8'h00);
      chk("unmapped read", sfwdg_pkg::UNMAPPED_READ, q);
      $display("test reset done");
   endtask : t_reset

   task automatic t_count;
      logic [7:0] a;
      bus(1'b0, CTL, 8'h00);
      a = q[7:0] - 8'h05;
      // data edges of the two reads lie exactly five steps apart
      repeat (36) @(posedge clock);
      bus(1'b0, CTL, 8'h00);
      chk("count step", {25'h000_0000, a[6:0]}, q);
      roll(8'h41, 0);
      bus(1'b0, CTL, 8'h00);
      chk("count runs", 32'h0, {31'h0000_0000, q[6]});
      $display("test count done");
   endtask : t_count

   task automatic t_active;
      int r0;
      roll(8'hC1, 1);
      bus(1'b1, CTL, 8'hFF);
      halt_try(1'b1, 1, 0);
      // refresh first, so a later wake-up starts from a full count
      bus(1'b1, CTL, 8'hFF);
      halt_try(1'b0, 0, 1);
      bus(1'b1, CTL, 8'h7F);
      bus(1'b0, CTL, 8'h00);
      chk("activation kept", 32'h1, {31'h0000_0000, q[7]});
      r0 = rst_seen;
      bus(1'b1, CTL, 8'h80);
      repeat (3) @(posedge clock);
      chk("software reset", r0 + 1, rst_seen);
      rst_dut();
      bus(1'b0, CTL, 8'h00);
      chk("activation cleared", 32'h0, {31'h0000_0000, q[7]});
      halt_try(1'b1, 0, 1);
      $display("test active done");
   endtask : t_active

   task automatic t_hw;
      hw <= 1'b1;
      rst_dut();
      roll(8'h41, 1);
      bus(1'b0, OPT, 8'h00);
      chk("hw enable", 32'h0000_0007, q);
      hw <= 1'b0;
      rst_dut();
      $display("test hardware option done");
   endtask : t_hw

   // first tick after a write may come anywhere within one period
   task automatic t_timing;
      int r0;
      r0 = rst_seen;
      bus(1'b1, CTL, 8'hC0);
      repeat (PER) @(posedge clock);
      chk("short timeout", r0 + 1, rst_seen);
      bus(1'b1, CTL, 8'hFF);
      repeat (63 * PER - 2) @(posedge clock);
      chk("long timeout early", r0 + 1, rst_seen);
      repeat (10) @(posedge clock);
      chk("long timeout", r0 + 2, rst_seen);
      $display("test timing done");
   endtask : t_timing

   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   // ***************************************************
   // sequence and watchdog
   // ***************************************************
   initial begin
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      t_reset();
      t_count();
      t_active();
      t_timing();
      t_hw();
      conclude();
   end

   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      $display("watchdog timeout");
      conclude();
   end
endmodule : testbench
`default_nettype wire
